/* File: smr_pkg.sv */
// package: constants, register map and state codes of the supply monitor reset block
package smr_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 20; // system clock rate in MHz
  localparam int unsigned TURN_ON_US = 100; // monitor settling time in microseconds
  localparam int unsigned STAB_CYCLES = TURN_ON_US * CLK_MHZ; // settling time in cycles
  localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
  localparam logic [2:0] PULSE_LAST = 3'h3; // one-shot reset lasts four cycles

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hFF;
  localparam logic [7:0] IDX_RST_SOURCE = 8'h01;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h02;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h03;
  localparam logic [31:0] ADDR_CONTROL = {22'h000000, IDX_CONTROL, 2'h0};
  localparam logic [31:0] ADDR_RST_SOURCE = {22'h000000, IDX_RST_SOURCE, 2'h0};
  localparam logic [31:0] ADDR_IRQ_STATUS = {22'h000000, IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] ADDR_IRQ_MASK = {22'h000000, IDX_IRQ_MASK, 2'h0};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CTL_ENABLE_BIT = 7;
  localparam int unsigned CTL_LEVEL_BIT = 6;
  localparam int unsigned RS_SELECT_BIT = 1; // write: select monitor, read: power-on flag
  localparam int unsigned RS_SOFT_BIT = 4; // write one: software reset
  localparam int unsigned EV_FAIL_BIT = 0;
  localparam int unsigned EV_RECOVER_BIT = 1;
  localparam int unsigned EV_BADSEL_BIT = 2;
  localparam logic ENABLE_RST = 1'b1;
  localparam logic POR_FLAG_RST = 1'b1;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ---------------------------------------------------------------
  // reset sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SMR_RUN = 2'b00,
    SMR_PULSE = 2'b01,
    SMR_FAIL = 2'b10
  } smr_state_e;

endpackage

/* File: smr_supply_monitor_reset.sv */
// module: supply monitor reset logic with an AHB-Lite register slave
//
// Behaviour
// RULE1 - low supply drives pin low, holds reset
// RULE2 - recovered supply releases the monitor reset
// RULE3 - power-fail reset leaves data memory untouched
// RULE4 - power-on reset enables the monitor
// RULE5 - other resets keep the monitor enable
// RULE6 - selecting unsettled monitor gives a system reset
// RULE7 - software enables monitor before selecting it
// RULE8 - enable, wait settling time, then select
// RULE9 - control bit 7 is read-write monitor enable
// RULE10 - power-on exit sets power-on flag bit 1
// RULE11 - bit 6 shows supply level, rest reserved
// RULE12 - monitor resets only when enabled and selected
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module smr_supply_monitor_reset (
  // clock and power-on reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // analog monitor
  input wire logic supply_ok_i,
  output logic monitor_on_o,
  // reset outputs
  output logic sys_reset_o,
  output logic mem_write_block_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  // interrupt
  output logic irq_o
);
  import smr_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  smr_state_e state_q, state_d;
  logic access;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic wr_control, wr_source, wr_status, wr_mask;
  logic enable_q;
  logic select_q;
  logic stable_q;
  logic [11:0] stab_cnt_q;
  logic [2:0] pulse_cnt_q;
  logic por_flag_q;
  logic supply_ok_q;
  logic [2:0] status_q, mask_q, events;
  logic fail_cond, soft_req, badsel_req, pulse_req;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ---------------------------------------------------------------
  assign access = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;

  // latch write address phase for the data phase
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h00000000;
    end else begin
      wr_pend_q <= access & hwrite_i;
      if (access) begin
        wr_addr_q <= haddr_i;
      end
    end
  end

  // write strobes in the data phase; unmapped writes are dropped
  assign wr_control = wr_pend_q && (wr_addr_q == ADDR_CONTROL);
  assign wr_source = wr_pend_q && (wr_addr_q == ADDR_RST_SOURCE);
  assign wr_status = wr_pend_q && (wr_addr_q == ADDR_IRQ_STATUS);
  assign wr_mask = wr_pend_q && (wr_addr_q == ADDR_IRQ_MASK);

  // read data captured in the address phase; unmapped reads return zero
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h00000000;
    end else if (access && !hwrite_i) begin
      rdata_q <= 32'h00000000;
      case (haddr_i)
        ADDR_CONTROL: begin
          rdata_q[CTL_ENABLE_BIT] <= enable_q; // RULE9
          rdata_q[CTL_LEVEL_BIT] <= supply_ok_q; // RULE11
        end
        ADDR_RST_SOURCE: begin
          rdata_q[RS_SELECT_BIT] <= por_flag_q; // RULE10
        end
        ADDR_IRQ_STATUS: begin
          rdata_q[2:0] <= status_q;
        end
        ADDR_IRQ_MASK: begin
          rdata_q[2:0] <= mask_q;
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // monitor enable and settling
  // ---------------------------------------------------------------
  // enable only reset by power-on; later system resets never touch it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q <= ENABLE_RST; // RULE4
    end else if (wr_control) begin
      enable_q <= hwdata_i[CTL_ENABLE_BIT]; // RULE9 RULE5
    end
  end

  assign monitor_on_o = enable_q;

  // settling timer restarts each time the monitor is switched off
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stab_cnt_q <= 12'h000;
      stable_q <= 1'b0;
    end else if (!enable_q) begin
      stab_cnt_q <= 12'h000;
      stable_q <= 1'b0;
    end else if (!stable_q) begin
      stab_cnt_q <= stab_cnt_q + 12'h001;
      stable_q <= (stab_cnt_q == STAB_LAST);
    end
  end

  // supply level sampled for status and reset decisions
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_ok_q <= 1'b1;
    end else begin
      supply_ok_q <= supply_ok_i; // RULE11
    end
  end

  // ---------------------------------------------------------------
  // reset source selection
  // ---------------------------------------------------------------
  // selecting before settling is a reset request, and the one-shot clears it
  assign soft_req = wr_source && hwdata_i[RS_SOFT_BIT];
  assign badsel_req = wr_source && hwdata_i[RS_SELECT_BIT] && !(enable_q && stable_q); // RULE6
  assign pulse_req = soft_req | badsel_req;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      select_q <= 1'b0;
    end else if (state_q == SMR_PULSE) begin
      select_q <= 1'b0;
    end else if (wr_source) begin
      select_q <= hwdata_i[RS_SELECT_BIT];
    end
  end

  // monitor can reset only when switched on and selected
  assign fail_cond = enable_q && select_q && !supply_ok_q; // RULE12

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SMR_RUN: begin
        if (fail_cond) begin
          state_d = SMR_FAIL; // RULE1
        end else if (pulse_req) begin
          state_d = SMR_PULSE; // RULE6
        end
      end
      SMR_FAIL: begin
        if (!fail_cond) begin
          state_d = SMR_RUN; // RULE2
        end
      end
      SMR_PULSE: begin
        if (pulse_cnt_q == 3'h0) begin
          state_d = SMR_RUN;
        end
      end
      default: begin
        state_d = SMR_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= SMR_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // one-shot length counter
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cnt_q <= 3'h0;
    end else if (state_q == SMR_RUN) begin
      pulse_cnt_q <= PULSE_LAST;
    end else if (pulse_cnt_q != 3'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 3'h1;
    end
  end

  // power-on flag set by power-on reset, cleared by any other reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      por_flag_q <= POR_FLAG_RST; // RULE10
    end else if (state_q == SMR_RUN && state_d != SMR_RUN) begin
      por_flag_q <= 1'b0;
    end
  end

  // reset outputs; only the supply monitor pulls the pin low
  assign sys_reset_o = (state_q != SMR_RUN); // RULE1
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = (state_q == SMR_FAIL); // RULE1
  // memory writes are frozen so a reset leaves contents as they were
  assign mem_write_block_o = (state_q != SMR_RUN); // RULE3

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign events[EV_FAIL_BIT] = (state_q == SMR_RUN) && fail_cond;
  assign events[EV_RECOVER_BIT] = (state_q == SMR_FAIL) && !fail_cond;
  assign events[EV_BADSEL_BIT] = (state_q == SMR_RUN) && !fail_cond && badsel_req;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~(wr_status ? hwdata_i[2:0] : 3'h0)) | events;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q <= MASK_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata_i[2:0];
    end
  end

  assign irq_o = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic first_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  sequence s_fail_enter;
    (state_q == SMR_RUN) && fail_cond;
  endsequence

  sequence s_pin_held;
    sys_reset_o && rst_pin_oe_o && !rst_pin_o;
  endsequence

  sequence s_bad_select;
    (state_q == SMR_RUN) && !fail_cond && badsel_req;
  endsequence

  sequence s_one_shot;
    (sys_reset_o && !rst_pin_oe_o) [*4] ##1 !sys_reset_o;
  endsequence

  sequence s_read_control;
    access && !hwrite_i && (haddr_i == ADDR_CONTROL);
  endsequence

  a_fail_holds_pin: assert property (s_fail_enter |=> s_pin_held) // RULE1
    else $error("low supply did not drive the reset pin");

  a_fail_stays: assert property ((state_q == SMR_FAIL) && fail_cond |=> s_pin_held) // RULE1
    else $error("reset released while supply still low");

  a_recover_release: assert property
    ((state_q == SMR_FAIL) && !fail_cond |=> !sys_reset_o && !rst_pin_oe_o) // RULE2
    else $error("recovered supply did not release reset");

  a_mem_frozen: assert property (rst_pin_oe_o |-> mem_write_block_o) // RULE3
    else $error("memory writes open during power-fail reset");

  a_enable_at_por: assert property (first_q |-> enable_q && por_flag_q) // RULE4 RULE10
    else $error("enable or power-on flag wrong after power-on");

  a_enable_kept: assert property ((state_q == SMR_PULSE) |=> $stable(enable_q)) // RULE5
    else $error("monitor enable changed by a system reset");

  a_badsel_reset: assert property (s_bad_select |=> s_one_shot) // RULE6
    else $error("early selection did not give a four cycle reset");

  a_control_read: assert property (s_read_control |=>
    hrdata_o[CTL_ENABLE_BIT] == $past(enable_q) && hrdata_o[CTL_LEVEL_BIT] == $past(supply_ok_q)
    && hrdata_o[5:0] == 6'h00) // RULE9 RULE11
    else $error("control register read mismatch");

  a_gated_monitor: assert property (!(enable_q && select_q) |=> state_q != SMR_FAIL) // RULE12
    else $error("monitor reset without enable and select");

endmodule

/* File: smr_testbench.sv */
// testbench: self-checking bench of the supply monitor reset block
`timescale 1ns/10ps
module testbench;
  import smr_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h00000000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h00000000;
  logic supply_ok_i = 1'b1;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, monitor_on_o, sys_reset_o;
  logic mem_write_block_o, rst_pin_o, rst_pin_oe_o, irq_o;
  int errors = 0;
  int checks_done = 0;
  int seed = 82743;
  int hs, hp, hm;
  logic [31:0] rd, v;

  // the one slave's hreadyout is the bus hready
  smr_supply_monitor_reset dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .supply_ok_i(supply_ok_i), .monitor_on_o(monitor_on_o),
    .sys_reset_o(sys_reset_o), .mem_write_block_o(mem_write_block_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .irq_o(irq_o));

  // free-running 20 MHz clock
  always #25 clock_i = ~clock_i;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // verdict and end of run
  task automatic tally_and_finish();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for an edge with hready high
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 100) begin
        errors++;
        tally_and_finish();
      end
      @(posedge clock_i);
    end
  endtask

  // one single ahb-lite word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    wait_ready();
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0);
  endtask

  // count cycles with reset, pin drive and memory block high
  task automatic watch(input int n);
    hs = 0;
    hp = 0;
    hm = 0;
    repeat (n) begin
      @(negedge clock_i);
      hs += int'(sys_reset_o === 1'b1);
      hp += int'(rst_pin_oe_o === 1'b1);
      hm += int'(mem_write_block_o === 1'b1);
    end
    @(posedge clock_i);
  endtask

  // expected control register image
  function automatic logic [31:0] ctl_exp(input logic en, input logic lvl);
    return {24'h000000, en, lvl, 6'h00};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    // reset state of the register map
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, ctl_exp(1'b1, 1'b1));
    chk({31'h0, monitor_on_o}, 32'h1);
    bus(1'b0, ADDR_RST_SOURCE, 32'h0);
    chk(rd, 32'h00000002);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h00000040, 32'h0);
    chk(rd, 32'h0);
    // selecting the unsettled monitor gives a one-shot system reset
    bus(1'b1, ADDR_RST_SOURCE, 32'h00000002);
    watch(8);
    chk(hs, 4);
    chk(hp, 0);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h00000004);
    chk({31'h0, irq_o}, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h00000004);
    @(negedge clock_i);
    chk({31'h0, irq_o}, 32'h1);
    @(posedge clock_i);
    bus(1'b0, ADDR_RST_SOURCE, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h00000004);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    // random control writes: enable read-write, reserved bits read zero
    repeat (6) begin
      v = $random(seed);
      bus(1'b1, ADDR_CONTROL, v);
      bus(1'b0, ADDR_CONTROL, 32'h0);
      chk(rd, ctl_exp(v[7], 1'b1));
    end
    // a software reset keeps the monitor disabled
    bus(1'b1, ADDR_CONTROL, 32'h0);
    bus(1'b1, ADDR_RST_SOURCE, 32'h00000010);
    watch(8);
    chk(hs, 4);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, ctl_exp(1'b0, 1'b1));
    chk({31'h0, monitor_on_o}, 32'h0);
    // enabled but not selected: supply dips cause no reset
    bus(1'b1, ADDR_CONTROL, 32'h00000080);
    hs = 0;
    repeat (20) begin
      supply_ok_i <= 1'($random(seed));
      @(negedge clock_i);
      hs += int'(sys_reset_o === 1'b1 || rst_pin_oe_o === 1'b1);
      @(posedge clock_i);
    end
    chk(hs, 0);
    supply_ok_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, ctl_exp(1'b1, 1'b0));
    supply_ok_i <= 1'b1;
    // settle, then select: no reset while the supply is good
    repeat (STAB_CYCLES + 100) @(posedge clock_i);
    bus(1'b1, ADDR_IRQ_MASK, 32'h00000003);
    bus(1'b1, ADDR_RST_SOURCE, 32'h00000002);
    watch(8);
    chk(hs, 0);
    // power fail holds reset and drives the pin, recovery releases
    supply_ok_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    watch(12);
    chk(hs, 12);
    chk(hp, 12);
    chk(hm, 12);
    chk({31'h0, rst_pin_o}, 32'h0);
    supply_ok_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    watch(8);
    chk(hs + hp + hm, 0);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd & 32'h00000003, 32'h00000003);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, ctl_exp(1'b1, 1'b1));
    // a mid-run power-on reset re-enables a disabled monitor and sets the flag
    bus(1'b1, ADDR_CONTROL, 32'h0);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk({31'h0, monitor_on_o}, 32'h1);
    chk({31'h0, sys_reset_o | rst_pin_oe_o | irq_o}, 32'h0);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, ctl_exp(1'b1, 1'b1));
    bus(1'b0, ADDR_RST_SOURCE, 32'h0);
    chk(rd, 32'h00000002);
    tally_and_finish();
  end
endmodule
